/* File: shared/instr_decode_map.svh */
`ifndef INSTR_DECODE_MAP_SVH
`define INSTR_DECODE_MAP_SVH

`define IWORD_W        14
`define PC_W           15
`define STACK_DEPTH    16
`define OSC_PER_CYCLE  4
`define NOP_WORD       14'h0000
`define PC_RESET       15'h0000
`define INDIRECT_BASE  7'h00
`define INDIRECT_MASK  7'h7e

`define OP_CALL        14'b10_0???_????_????
`define OP_JUMP        14'b10_1???_????_????
`define OP_RETURN      14'b00_0000_0000_1000
`define OP_RETINT      14'b00_0000_0000_1001
`define OP_WCALL       14'b00_0000_0000_1010
`define OP_WBR         14'b00_0000_0000_1011
`define OP_MOVIW       14'b00_0000_0001_0???
`define OP_MOVWI       14'b00_0000_0001_1???
`define OP_CLRW        14'b00_0001_0000_00??
`define OP_MOVWF       14'b00_0000_1???_????
`define OP_DECSKIP     14'b00_1011_????_????
`define OP_INCSKIP     14'b00_1111_????_????
`define OP_BCF         14'b01_00??_????_????
`define OP_BSF         14'b01_01??_????_????
`define OP_SKIPCLR     14'b01_10??_????_????
`define OP_SKIPSET     14'b01_11??_????_????
`define OP_MOVLW       14'b11_0000_????_????
`define OP_RELBR       14'b11_001?_????_????
`define OP_RETK        14'b11_0100_????_????
`define OP_LSLF        14'b11_0101_????_????
`define OP_LSRF        14'b11_0110_????_????
`define OP_ASRF        14'b11_0111_????_????
`define OP_IORLW       14'b11_1000_????_????
`define OP_ANDLW       14'b11_1001_????_????
`define OP_XORLW       14'b11_1010_????_????
`define OP_SUBWFB      14'b11_1011_????_????
`define OP_SUBLW       14'b11_1100_????_????
`define OP_ADDWFC      14'b11_1101_????_????
`define OP_ADDLW       14'b11_1110_????_????

`endif

/* File: shared/instr_decode_pkg.sv */
package instr_decode_pkg;
    typedef enum logic [1:0] {CLASS_BYTE, CLASS_BIT, CLASS_LITCTL} op_class_e;
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_MODIFY, PH_STORE} phase_e;
    typedef enum logic [1:0] {
        STEP_PRE_INC, STEP_PRE_DEC, STEP_POST_INC, STEP_POST_DEC
    } pointer_step_mode_e;
    typedef enum logic [4:0] {
        ALU_PASS_F, ALU_PASS_W, ALU_ZERO, ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBB,
        ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_RR, ALU_RL,
        ALU_SWAP, ALU_ASR, ALU_LSL, ALU_LSR, ALU_BCLR, ALU_BSET
    } alu_op_e;
endpackage : instr_decode_pkg

/* File: src/return_stack.sv */
`include "instr_decode_map.svh"

module return_stack #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int WIDTH = `PC_W
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // stack access
    input  wire logic             push_i,
    input  wire logic             pop_i,
    input  wire logic [WIDTH-1:0] push_data_i,
    output logic      [WIDTH-1:0] top_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    ptr;
    wire  [AW-1:0]    top_idx = ptr - AW'(1);

    // circular: overflow silently overwrites the oldest entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr <= '0;
        end else if (push_i) begin
            ptr <= ptr + AW'(1);
        end else if (pop_i) begin
            ptr <= top_idx;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push_i) begin
            mem[ptr] <= push_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            top_o <= '0;
        end else begin
            top_o <= mem[top_idx];
        end
    end
endmodule : return_stack

/* File: src/instr_decode_timing.sv */
// What this block does
// - each instruction is one 14-bit word
// - classify byte, bit, literal/control groups
// - single cycle except flow, taken skips and indirect access into program memory
// - both calls take two cycles
// - all three returns take two cycles
// - jumps, branches, taken skips take two
// - file field addresses 0x00 to 0x7F
// - bit field picks one of eight bits
// - destination bit zero W, one file
// - pointer field picks pair zero or one
// - decode pointer pre/post increment/decrement mode
// - don't-care bits ignored, software writes zero
// - extra cycle for indirect into program memory
// - instruction cycle is four clocks
// - file operands read, modify, then store
// - write-only file operands still read first
//
// Decided for this implementation: strobed register access and the placing of the registers.
`include "instr_decode_map.svh"

module instr_decode_timing (
    // clock and reset
    input  wire logic                                MCLK_I,
    input  wire logic                                SRST_I,
    // program memory
    output logic      [`PC_W-1:0]                    PM_ADDR_O,
    input  wire logic [`IWORD_W-1:0]                 PM_DATA_I,
    // file register space
    output logic      [6:0]                          FILE_ADDR_O,
    output logic                                     FILE_RD_O,
    input  wire logic [7:0]                          FILE_RDATA_I,
    output logic                                     FILE_WR_O,
    output logic      [7:0]                          FILE_WDATA_O,
    input  wire logic [1:0]                          INDIRECT_PM_I,
    // indirect pointer stepping
    output logic                                     PTR_STEP_O,
    output logic                                     PTR_SEL_O,
    output instr_decode_pkg::pointer_step_mode_e     STEP_MODE_O,
    // decode and status
    output instr_decode_pkg::op_class_e              OP_CLASS_O,
    output logic      [2:0]                          BIT_FIELD_O,
    output logic                                     DEST_FILE_O,
    output logic      [7:0]                          W_O,
    output logic                                     ZERO_O,
    output logic                                     CARRY_O,
    output logic                                     CYCLE_START_O,
    output logic                                     NOP_CYCLE_O
);
    import instr_decode_pkg::*;

    phase_e            phase;
    phase_e            next_phase;
    logic [`IWORD_W-1:0] ir;
    logic [`PC_W-1:0]  pc;
    logic [`PC_W-1:0]  next_pc;
    logic [`PC_W-1:0]  stack_top;
    logic [7:0]        w;
    logic [7:0]        result;
    logic [7:0]        alu_a;
    logic [7:0]        alu_res;
    logic [6:0]        file_addr;
    logic              zf;
    logic              cf;
    logic              res_c;
    logic              next_c;
    logic              skip_hit;
    logic              extra_done;
    logic              stall;
    logic              flushed;
    alu_op_e           alu_op;

    // instruction decode
    wire is_misc    = (ir[13:7] == 7'h00);
    wire is_byte00  = (ir[13:12] == 2'b00) && !is_misc;
    wire is_byte11  = (ir ==? `OP_LSLF) || (ir ==? `OP_LSRF) || (ir ==? `OP_ASRF)
                    || (ir ==? `OP_SUBWFB) || (ir ==? `OP_ADDWFC);
    wire is_byte    = is_byte00 || is_byte11;
    wire is_bitop   = (ir[13:12] == 2'b01);
    wire is_clrw    = (ir ==? `OP_CLRW);
    wire is_movwf   = (ir ==? `OP_MOVWF);
    wire is_skipcnt = (ir ==? `OP_DECSKIP) || (ir ==? `OP_INCSKIP);
    wire is_bcf     = (ir ==? `OP_BCF);
    wire is_bsf     = (ir ==? `OP_BSF);
    wire is_skipclr = (ir ==? `OP_SKIPCLR);
    wire is_skipset = (ir ==? `OP_SKIPSET);
    wire is_call    = (ir ==? `OP_CALL);
    wire is_jump    = (ir ==? `OP_JUMP);
    wire is_wcall   = (ir ==? `OP_WCALL);
    wire is_relbr   = (ir ==? `OP_RELBR);
    wire is_wbr     = (ir ==? `OP_WBR);
    wire is_retk    = (ir ==? `OP_RETK);
    wire is_ret     = (ir ==? `OP_RETURN) || (ir ==? `OP_RETINT) || is_retk;
    wire is_moviw   = (ir ==? `OP_MOVIW);
    wire is_movwi   = (ir ==? `OP_MOVWI);
    wire is_movlw   = (ir ==? `OP_MOVLW);
    wire is_iorlw   = (ir ==? `OP_IORLW);
    wire is_andlw   = (ir ==? `OP_ANDLW);
    wire is_xorlw   = (ir ==? `OP_XORLW);
    wire is_sublw   = (ir ==? `OP_SUBLW);
    wire is_addlw   = (ir ==? `OP_ADDLW);
    wire lit_alu    = is_movlw || is_retk || is_iorlw || is_andlw || is_xorlw
                    || is_sublw || is_addlw;
    wire uses_ptr   = is_moviw || is_movwi;
    wire is_btest   = is_skipclr || is_skipset;
    wire is_skip    = is_btest || is_skipcnt;

    // clear-w carries two don't-care bits in its file field: no access at all
    wire uses_file  = (is_byte && !is_clrw) || is_bitop || uses_ptr;
    wire [6:0] addr_field = uses_ptr ? (`INDIRECT_BASE | {6'h00, ir[2]}) : ir[6:0];
    wire ptr_sel    = uses_ptr ? ir[2] : ir[0];
    wire ind_hit    = uses_file && ((addr_field & `INDIRECT_MASK) == `INDIRECT_BASE);
    wire need_extra = ind_hit && INDIRECT_PM_I[ptr_sel] && !extra_done;
    wire dest_w     = (is_byte && !ir[7]) || lit_alu || is_moviw;
    wire dest_file  = (is_byte && ir[7]) || is_bcf || is_bsf || is_movwi;
    wire [2:0] bit_sel = ir[9:7];
    wire [7:0] bit_mask = 8'h01 << bit_sel;
    wire do_store   = (phase == PH_STORE) && !stall;
    wire flow_jump  = is_call || is_wcall || is_jump || is_relbr || is_wbr || is_ret;
    wire flow_taken = flow_jump || (is_skip && skip_hit);
    wire z_upd      = (is_byte || (lit_alu && !is_movlw && !is_retk)) && !is_skipcnt
                    && !is_movwf && (alu_op != ALU_RR) && (alu_op != ALU_RL)
                    && (alu_op != ALU_SWAP);
    wire c_upd      = (alu_op == ALU_ADD) || (alu_op == ALU_ADDC) || (alu_op == ALU_SUB)
                    || (alu_op == ALU_SUBB) || (alu_op == ALU_RR) || (alu_op == ALU_RL)
                    || (alu_op == ALU_ASR) || (alu_op == ALU_LSL) || (alu_op == ALU_LSR);
    wire bit_now    = FILE_RDATA_I[bit_sel];
    wire skip_cond  = (is_skipclr && !bit_now) || (is_skipset && bit_now)
                    || (is_skipcnt && (alu_res == 8'h00));
    wire [`PC_W-1:0] rel_off = {{6{ir[8]}}, ir[8:0]};

    // operation group
    assign OP_CLASS_O = is_byte ? CLASS_BYTE : (is_bitop ? CLASS_BIT : CLASS_LITCTL);

    // byte-group nibble and literal ops share one alu
    always_comb begin
        alu_op = ALU_PASS_F;
        if (is_byte00) begin
            unique case (ir[11:8])
                4'h0: alu_op = ALU_PASS_W;
                4'h1: alu_op = ALU_ZERO;
                4'h2: alu_op = ALU_SUB;
                4'h3: alu_op = ALU_DEC;
                4'h4: alu_op = ALU_IOR;
                4'h5: alu_op = ALU_AND;
                4'h6: alu_op = ALU_XOR;
                4'h7: alu_op = ALU_ADD;
                4'h8: alu_op = ALU_PASS_F;
                4'h9: alu_op = ALU_COM;
                4'ha: alu_op = ALU_INC;
                4'hb: alu_op = ALU_DEC;
                4'hc: alu_op = ALU_RR;
                4'hd: alu_op = ALU_RL;
                4'he: alu_op = ALU_SWAP;
                4'hf: alu_op = ALU_INC;
            endcase
        end else if (ir ==? `OP_LSLF) begin
            alu_op = ALU_LSL;
        end else if (ir ==? `OP_LSRF) begin
            alu_op = ALU_LSR;
        end else if (ir ==? `OP_ASRF) begin
            alu_op = ALU_ASR;
        end else if (ir ==? `OP_SUBWFB) begin
            alu_op = ALU_SUBB;
        end else if (ir ==? `OP_ADDWFC) begin
            alu_op = ALU_ADDC;
        end else if (is_bcf) begin
            alu_op = ALU_BCLR;
        end else if (is_bsf) begin
            alu_op = ALU_BSET;
        end else if (is_movwi) begin
            alu_op = ALU_PASS_W;
        end else if (is_iorlw) begin
            alu_op = ALU_IOR;
        end else if (is_andlw) begin
            alu_op = ALU_AND;
        end else if (is_xorlw) begin
            alu_op = ALU_XOR;
        end else if (is_sublw) begin
            alu_op = ALU_SUB;
        end else if (is_addlw) begin
            alu_op = ALU_ADD;
        end
    end

    // modify step: literal or freshly read file data
    assign alu_a = lit_alu ? ir[7:0] : FILE_RDATA_I;

    always_comb begin
        alu_res = alu_a;
        next_c  = cf;
        unique case (alu_op)
            ALU_PASS_F: alu_res = alu_a;
            ALU_PASS_W: alu_res = w;
            ALU_ZERO:   alu_res = 8'h00;
            ALU_ADD:    {next_c, alu_res} = {1'b0, alu_a} + {1'b0, w};
            ALU_ADDC:   {next_c, alu_res} = {1'b0, alu_a} + {1'b0, w} + {8'h00, cf};
            ALU_SUB:    {next_c, alu_res} = {1'b0, alu_a} + {1'b0, ~w} + 9'h001;
            ALU_SUBB:   {next_c, alu_res} = {1'b0, alu_a} + {1'b0, ~w} + {8'h00, cf};
            ALU_AND:    alu_res = alu_a & w;
            ALU_IOR:    alu_res = alu_a | w;
            ALU_XOR:    alu_res = alu_a ^ w;
            ALU_COM:    alu_res = ~alu_a;
            ALU_INC:    alu_res = alu_a + 8'h01;
            ALU_DEC:    alu_res = alu_a - 8'h01;
            ALU_RR:     {alu_res, next_c} = {cf, alu_a};
            ALU_RL:     {next_c, alu_res} = {alu_a, cf};
            ALU_SWAP:   alu_res = {alu_a[3:0], alu_a[7:4]};
            ALU_ASR:    {alu_res, next_c} = {alu_a[7], alu_a};
            ALU_LSL:    {next_c, alu_res} = {alu_a, 1'b0};
            ALU_LSR:    {alu_res, next_c} = {1'b0, alu_a};
            ALU_BCLR:   alu_res = alu_a & ~bit_mask;
            ALU_BSET:   alu_res = alu_a | bit_mask;
        endcase
    end

    // flow target selection
    always_comb begin
        next_pc = pc + `PC_W'(1);
        if (is_call || is_jump) begin
            next_pc = {pc[14:11], ir[10:0]};
        end else if (is_wcall) begin
            next_pc = {pc[14:8], w};
        end else if (is_relbr) begin
            next_pc = pc + rel_off;
        end else if (is_wbr) begin
            next_pc = pc + {7'h00, w};
        end else if (is_ret) begin
            next_pc = stack_top;
        end
    end

    // four-clock instruction cycle
    always_comb begin
        unique case (phase)
            PH_DECODE: next_phase = PH_READ;
            PH_READ:   next_phase = PH_MODIFY;
            PH_MODIFY: next_phase = PH_STORE;
            PH_STORE:  next_phase = PH_DECODE;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            phase <= PH_DECODE;
        end else begin
            phase <= next_phase;
        end
    end

    // stall decision frozen for the whole cycle, so a pointer change mid-cycle is harmless
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            stall     <= 1'b0;
            file_addr <= 7'h00;
        end else if (phase == PH_DECODE) begin
            stall     <= need_extra;
            file_addr <= uses_file ? addr_field : 7'h00;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            result   <= 8'h00;
            res_c    <= 1'b0;
            skip_hit <= 1'b0;
        end else if (phase == PH_MODIFY) begin
            result   <= alu_res;
            res_c    <= next_c;
            skip_hit <= skip_cond;
        end
    end

    // store step, fetch and flush
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            ir         <= `NOP_WORD;
            pc         <= `PC_RESET;
            flushed    <= 1'b0;
            extra_done <= 1'b0;
        end else if (phase == PH_STORE) begin
            if (stall) begin
                extra_done <= 1'b1;
            end else begin
                ir         <= flow_taken ? `NOP_WORD : PM_DATA_I;
                pc         <= next_pc;
                flushed    <= flow_taken;
                extra_done <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            w  <= 8'h00;
            zf <= 1'b0;
            cf <= 1'b0;
        end else if (do_store) begin
            if (dest_w) begin
                w <= result;
            end
            if (z_upd) begin
                zf <= (result == 8'h00);
            end
            if (c_upd) begin
                cf <= res_c;
            end
        end
    end

    return_stack u_stack (
        .clk_i       (MCLK_I),
        .rst_i       (SRST_I),
        .push_i      (do_store && (is_call || is_wcall)),
        .pop_i       (do_store && is_ret),
        .push_data_i (pc),
        .top_o       (stack_top)
    );

    // strobes stay combinational; data come from flops
    assign FILE_RD_O     = (phase == PH_READ) && uses_file && !stall;
    assign FILE_WR_O     = do_store && dest_file;
    assign FILE_WDATA_O  = result;
    assign FILE_ADDR_O   = file_addr;
    assign PTR_STEP_O    = do_store && uses_ptr;
    assign PTR_SEL_O     = ptr_sel;
    assign STEP_MODE_O   = pointer_step_mode_e'(ir[1:0]);
    assign BIT_FIELD_O   = bit_sel;
    assign DEST_FILE_O   = dest_file;
    assign PM_ADDR_O     = pc;
    assign W_O           = w;
    assign ZERO_O        = zf;
    assign CARRY_O       = cf;
    assign CYCLE_START_O = (phase == PH_DECODE);
    assign NOP_CYCLE_O   = flushed;

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SRST_I);

    property p_cycle_four;
        (CYCLE_START_O && !SRST_I) |-> ##1 !CYCLE_START_O [*3] ##1 CYCLE_START_O;
    endproperty
    a_cycle_four: assert property (p_cycle_four) else $error("cycle not four clocks");

    property p_read_before_write;
        FILE_WR_O |-> $past(FILE_RD_O, 2);
    endproperty
    a_read_before_write: assert property (p_read_before_write)
        else $error("file write without read");

    property p_movwf_reads;
        (do_store && is_movwf) |-> FILE_WR_O && $past(FILE_RD_O, 2);
    endproperty
    a_movwf_reads: assert property (p_movwf_reads) else $error("write-only op skipped read");

    property p_file_field;
        (FILE_RD_O && is_byte) |-> FILE_ADDR_O == ir[6:0];
    endproperty
    a_file_field: assert property (p_file_field) else $error("wrong file address");

    property p_bit_set;
        (FILE_WR_O && is_bsf) |-> FILE_WDATA_O == ($past(FILE_RDATA_I) | (8'h01 << ir[9:7]));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set wrong bit");

    property p_dest_w;
        (do_store && is_byte && !ir[7]) |-> !FILE_WR_O ##1 W_O == $past(result);
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("w destination wrong");

    property p_jump_target;
        (do_store && is_jump) |=> PM_ADDR_O == $past({pc[14:11], ir[10:0]});
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

    property p_call_flush;
        (do_store && (is_call || is_wcall)) |=> NOP_CYCLE_O [*4] ##1 !NOP_CYCLE_O;
    endproperty
    a_call_flush: assert property (p_call_flush) else $error("call not two cycles");

    property p_return;
        (do_store && is_ret) |=> PM_ADDR_O == $past(stack_top) && NOP_CYCLE_O;
    endproperty
    a_return: assert property (p_return) else $error("return target wrong");

    property p_extra;
        (phase == PH_STORE && stall) |-> !FILE_WR_O ##1 ($stable(ir) && $stable(pc));
    endproperty
    a_extra: assert property (p_extra) else $error("extra cycle not held");

    property p_single;
        (do_store && !flow_taken) |=> !NOP_CYCLE_O [*4];
    endproperty
    a_single: assert property (p_single) else $error("plain op took extra cycle");

    property p_clrw;
        (phase == PH_READ && is_clrw) |-> !FILE_RD_O;
    endproperty
    a_clrw: assert property (p_clrw) else $error("don't-care field accessed");
endmodule : instr_decode_timing

/* File: verif/prog_mem_model.sv */
`include "instr_decode_map.svh"

module prog_mem_model #(
    parameter int LATENCY = 2
) (
    // clock
    input  wire logic                 clk_i,
    // fetch port
    input  wire logic [`PC_W-1:0]     addr_i,
    output logic      [`IWORD_W-1:0]  data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [`IWORD_W-1:0] mem [256];
    logic [`PC_W-1:0]    prev;
    int                  age;

    // whole word per fetch; garbage until a slow fetch settles
    assign data_o = (addr_i == prev && age >= LATENCY - 1) ? mem[addr_i[7:0]]
                                                           : ~mem[prev[7:0]];
    always_ff @(posedge clk_i) begin
        prev <= addr_i;
        age  <= (addr_i != prev) ? 0 : age + 1;
    end
endmodule : prog_mem_model

/* File: verif/tb_instr_decode_timing.sv */
`include "instr_decode_map.svh"

module tb_instr_decode_timing;
    timeunit 1ns;
    timeprecision 100ps;
    import instr_decode_pkg::*;

    logic                MCLK_I, SRST_I, FILE_RD_O, FILE_WR_O, PTR_STEP_O, PTR_SEL_O;
    logic                DEST_FILE_O, ZERO_O, CARRY_O, CYCLE_START_O, NOP_CYCLE_O;
    logic [`PC_W-1:0]    PM_ADDR_O;
    logic [`IWORD_W-1:0] PM_DATA_I;
    logic [6:0]          FILE_ADDR_O;
    logic [7:0]          FILE_RDATA_I, FILE_WDATA_O, W_O;
    logic [1:0]          INDIRECT_PM_I;
    logic [2:0]          BIT_FIELD_O;
    pointer_step_mode_e  STEP_MODE_O;
    op_class_e           OP_CLASS_O;
    logic [7:0]          fmem [128];
    int                  failures = 0;
    int                  comparisons = 0;
    typedef struct {
        logic [14:0] pa;
        logic [1:0]  cls, md;
        logic        nop, dst, st, sel, z, c;
        logic [7:0]  w, ra, wa, wd;
        logic [2:0]  bf;
        int          rc, wc, len;
    } rec_s;
    rec_s                r [24];

    instr_decode_timing u_dut (.MCLK_I, .SRST_I, .PM_ADDR_O, .PM_DATA_I, .FILE_ADDR_O,
        .FILE_RD_O, .FILE_RDATA_I, .FILE_WR_O, .FILE_WDATA_O, .INDIRECT_PM_I, .PTR_STEP_O,
        .PTR_SEL_O, .STEP_MODE_O, .OP_CLASS_O, .BIT_FIELD_O, .DEST_FILE_O, .W_O, .ZERO_O,
        .CARRY_O, .CYCLE_START_O, .NOP_CYCLE_O);
    prog_mem_model #(.LATENCY(2)) u_pm (.clk_i(MCLK_I), .addr_i(PM_ADDR_O), .data_o(PM_DATA_I));

    initial begin
        MCLK_I = 1'b0;
        forever #2 MCLK_I = ~MCLK_I;
    end
    // file space: data only in the clock after the strobe
    always @(posedge MCLK_I) begin
        FILE_RDATA_I <= FILE_RD_O ? fmem[FILE_ADDR_O] : ~FILE_RDATA_I;
        if (FILE_WR_O) fmem[FILE_ADDR_O] <= FILE_WDATA_O;
    end

    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // entered at the falling edge inside phase decode
    task automatic step(output rec_s x);
        x = '{pa: PM_ADDR_O, cls: OP_CLASS_O, nop: NOP_CYCLE_O, dst: DEST_FILE_O, st: 0,
              sel: PTR_SEL_O, w: W_O, md: STEP_MODE_O, bf: BIT_FIELD_O, ra: 0, wa: 0,
              wd: 0, rc: 9, wc: 9, len: 0, z: ZERO_O, c: CARRY_O};
        for (int i = 0; i < 12; i++) begin
            if (FILE_RD_O === 1'b1) begin
                x.rc = i;
                x.ra = {1'b0, FILE_ADDR_O};
            end
            if (FILE_WR_O === 1'b1) begin
                x.wc = i;
                x.wa = {1'b0, FILE_ADDR_O};
                x.wd = FILE_WDATA_O;
            end
            if (PTR_STEP_O === 1'b1) x.st = 1'b1;
            @(negedge MCLK_I);
            x.len = i + 1;
            if (CYCLE_START_O === 1'b1) break;
        end
    endtask : step

    task automatic wipe();
        for (int i = 0; i < 256; i++) u_pm.mem[i] = 14'h0000;
        for (int i = 0; i < 128; i++) fmem[i] = 8'h00;
    endtask : wipe

    task automatic boot(logic [1:0] ipm, int n);
        @(posedge MCLK_I);
        SRST_I <= 1'b1;
        INDIRECT_PM_I <= ipm;
        repeat (2) @(posedge MCLK_I);
        SRST_I <= 1'b0;
        @(negedge MCLK_I);
        chk(CYCLE_START_O, 1);
        for (int i = 0; i < n; i++) step(r[i]);
    endtask : boot

    // expected {flushed, fetch address} per executed cycle
    task automatic chk_seq(logic [15:0] e[$]);
        foreach (e[i]) begin
            chk({r[i + 1].nop, r[i + 1].pa}, e[i]);
            chk(r[i + 1].len, 4);
        end
    endtask : chk_seq

    task automatic test_byte();
        wipe();
        u_pm.mem[0] = 14'h305a;
        u_pm.mem[1] = 14'h00ff;
        u_pm.mem[2] = 14'h0821;
        u_pm.mem[3] = 14'h0103;
        u_pm.mem[4] = 14'h3c05;
        fmem[7'h21] = 8'hc3;
        boot(2'b00, 7);
        chk_seq('{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006});
        chk(r[1].cls, CLASS_LITCTL);
        chk(r[1].rc, 9);
        chk(r[2].cls, CLASS_BYTE);
        chk(r[2].rc, 1);
        chk(r[2].ra, 8'h7f);
        chk(r[2].wc, 3);
        chk(r[2].wa, 8'h7f);
        chk(r[2].wd, 8'h5a);
        chk(r[3].dst, 0);
        chk(r[3].ra, 8'h21);
        chk(r[3].wc, 9);
        chk(r[4].w, 8'hc3);
        chk(r[4].rc, 9);
        chk(r[5].w, 8'h00);
        chk(r[2].dst, 1);
        chk(r[4].z, 0);
        chk(r[5].z, 1);
        chk(r[6].w, 8'h05);
        chk(r[6].c, 1);
        chk(r[6].z, 0);
    endtask : test_byte

    task automatic test_flow();
        wipe();
        u_pm.mem[0] = 14'h2010;
        u_pm.mem[1] = 14'h2808;
        u_pm.mem[8] = 14'h3202;
        u_pm.mem[11] = 14'h2018;
        u_pm.mem[12] = 14'h000a;
        u_pm.mem[13] = 14'h3002;
        u_pm.mem[14] = 14'h000b;
        u_pm.mem[16] = 14'h3477;
        u_pm.mem[24] = 14'h0008;
        u_pm.mem[119] = 14'h0009;
        boot(2'b00, 21);
        chk_seq('{16'h0001, 16'h8010, 16'h0011, 16'h8001, 16'h0002, 16'h8008, 16'h0009,
                  16'h800b, 16'h000c, 16'h8018, 16'h0019, 16'h800c, 16'h000d, 16'h8077,
                  16'h0078, 16'h800d, 16'h000e, 16'h000f, 16'h8011, 16'h0012});
        chk(r[5].w, 8'h77);
    endtask : test_flow

    task automatic test_skip();
        wipe();
        u_pm.mem[0] = 14'h1930;
        u_pm.mem[1] = 14'h1d30;
        u_pm.mem[2] = 14'h3011;
        u_pm.mem[3] = 14'h19b0;
        u_pm.mem[4] = 14'h3022;
        u_pm.mem[5] = 14'h0bb1;
        u_pm.mem[6] = 14'h3044;
        u_pm.mem[7] = 14'h0f32;
        fmem[7'h30] = 8'h04;
        fmem[7'h31] = 8'h01;
        fmem[7'h32] = 8'h05;
        boot(2'b00, 10);
        chk_seq('{16'h0001, 16'h0002, 16'h8003, 16'h0004, 16'h8005, 16'h0006, 16'h8007,
                  16'h0008, 16'h0009});
        chk(r[1].cls, CLASS_BIT);
        chk(r[1].bf, 2);
        chk(r[4].bf, 3);
        chk(r[6].wd, 8'h00);
        chk(r[8].w, 8'h00);
        chk(r[9].w, 8'h06);
    endtask : test_skip

    task automatic test_indirect();
        wipe();
        u_pm.mem[0] = 14'h0081;
        u_pm.mem[1] = 14'h0080;
        for (int m = 0; m < 4; m++) u_pm.mem[2 + m] = 14'h0014 | 14'(m);
        boot(2'b01, 8);
        chk_seq('{16'h0001, 16'h0002, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006});
        chk(r[1].wa, 8'h01);
        chk(r[2].rc, 9);
        chk(r[2].wc, 9);
        chk(r[3].wa, 8'h00);
        chk(r[1].st, 0);
        for (int m = 0; m < 4; m++) begin
            chk(r[4 + m].st, 1);
            chk(r[4 + m].md, m);
            chk(r[4 + m].sel, 1);
        end
    endtask : test_indirect

    initial begin
        repeat (4000) @(posedge MCLK_I);
        failures++;
        final_report();
    end

    initial begin
        SRST_I = 1'b1;
        INDIRECT_PM_I = 2'b00;
        FILE_RDATA_I = 8'h00;
        test_byte();
        test_flow();
        test_skip();
        test_indirect();
        final_report();
    end
endmodule : tb_instr_decode_timing
